/* verilog/drive_on_off_sequencer.sv */
module drive_on_off_sequencer
  import drive_seq_pkg::*;
(
  // clock, reset, enable
  input  wire logic              mclk_in,
  input  wire logic              resetn_in,
  input  wire logic              ce_in,
  // register port
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [DATA_W-1:0] rd_data_out,
  // digital command inputs
  input  wire logic              di_on_in,
  input  wire logic              di_coast_stop_in,
  input  wire logic              di_quick_stop_in,
  // ramp generator feedback
  input  wire logic              zero_speed_in,
  // drive outputs
  output logic                   motor_on_out,
  output logic                   ramp_normal_out,
  output logic                   ramp_quick_out,
  output logic      [6:0]        state_out
);

  // stored state
  logic [3:0] ctrl_word;    // fieldbus control word
  logic [1:0] config_bits;  // auto start and source select
  seq_state_e state;        // sequencer state
  seq_state_e next_state;   // value for next edge
  cmd_s       cmd;          // resolved commands
  drive_s     drive;        // registered drive outputs
  logic       auto_start;   // auto-start option, same-cycle write counts

  // motor energised in the running and braking states
  function automatic logic energised(input seq_state_e s);
    energised = (s == state_operation) || (s == state_normal_stop) ||
                (s == state_fast_stop);
  endfunction : energised

  // coast or quick stop pending; outside the energised states both force the inhibited state
  function automatic logic hard_stop(input cmd_s c);
    hard_stop = c.coast_stop_cmd || c.quick_stop_cmd;
  endfunction : hard_stop

  // power-up lasts one enabled cycle and the option resets to off, so
  // a write landing on that same edge must already count
  assign auto_start = (wr_in && addr_in == CONFIG_OFFSET) ?
                      wr_data_in[CFG_AUTO_BIT] : config_bits[CFG_AUTO_BIT];

  // command source mux
  always_comb begin
    if (config_bits[CFG_BUS_BIT]) begin
      // the master owns the enable bit here
      cmd.on_cmd         = ctrl_word[CTRL_ON_BIT];
      cmd.coast_stop_cmd = ctrl_word[CTRL_COAST_BIT];
      cmd.quick_stop_cmd = ctrl_word[CTRL_QUICK_BIT];
      cmd.op_enable      = ctrl_word[CTRL_ENABLE_BIT];
    end else begin
      // terminal control: enable tied active
      cmd.on_cmd         = di_on_in;
      cmd.coast_stop_cmd = di_coast_stop_in;
      cmd.quick_stop_cmd = di_quick_stop_in;
      cmd.op_enable      = 1'b1;
    end
  end

  // next-state decode; within each state the coast branch comes
  // first, then quick, then the ramped stop
  always_comb begin
    next_state = state;
    unique case (state)
      state_power_up: begin
        // first enabled cycle after reset looks at the inputs
        if (hard_stop(cmd)) begin
          next_state = state_switch_on_inhibited;
        end else if (cmd.on_cmd && !auto_start) begin
          next_state = state_switch_on_inhibited;
        end else begin
          // auto start keeps the on level live
          next_state = state_ready_to_switch_on;
        end
      end
      state_switch_on_inhibited: begin
        // on is ignored; leave only once on and both stops are idle
        if (!cmd.on_cmd && !hard_stop(cmd)) begin
          next_state = state_ready_to_switch_on;
        end
      end
      state_ready_to_switch_on: begin
        if (hard_stop(cmd)) begin
          next_state = state_switch_on_inhibited;
        end else if (cmd.on_cmd) begin
          next_state = state_await_enable;
        end
      end
      state_await_enable: begin
        if (hard_stop(cmd)) begin
          next_state = state_switch_on_inhibited;
        end else if (!cmd.on_cmd) begin
          next_state = state_ready_to_switch_on;
        end else if (cmd.op_enable) begin
          next_state = state_operation;
        end
      end
      state_operation: begin
        if (cmd.coast_stop_cmd) begin
          next_state = state_switch_on_inhibited;
        end else if (cmd.quick_stop_cmd) begin
          next_state = state_fast_stop;
        end else if (!cmd.on_cmd) begin
          next_state = state_normal_stop;
        end else if (!cmd.op_enable) begin
          // enable withdrawn: drop drive, wait for it again
          next_state = state_await_enable;
        end
      end
      state_normal_stop: begin
        if (cmd.coast_stop_cmd) begin
          next_state = state_switch_on_inhibited;
        end else if (cmd.quick_stop_cmd) begin
          next_state = state_fast_stop;
        end else if (zero_speed_in) begin
          next_state = state_ready_to_switch_on;
        end
      end
      state_fast_stop: begin
        // a ramped stop cannot soften a quick stop once begun
        if (cmd.coast_stop_cmd) begin
          next_state = state_switch_on_inhibited;
        end else if (zero_speed_in) begin
          next_state = state_switch_on_inhibited;
        end
      end
      default: begin
        // illegal one-hot code: park safely with drive off
        next_state = state_switch_on_inhibited;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= state_power_up;
    end else if (ce_in) begin
      state <= next_state;
    end
  end

  // drive outputs registered from the next state so they line up
  // with the state report; no extra cycle of drive after a coast
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      drive <= '0;
    end else if (ce_in) begin
      drive.motor_on    <= energised(next_state);
      drive.ramp_normal <= (next_state == state_normal_stop);
      drive.ramp_quick  <= (next_state == state_fast_stop);
    end
  end

  assign motor_on_out    = drive.motor_on;
  assign ramp_normal_out = drive.ramp_normal;
  assign ramp_quick_out  = drive.ramp_quick;
  assign state_out       = state;

  // register writes; status is read-only
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_word   <= CTRL_RESET;
      config_bits <= CONFIG_RESET;
    end else if (ce_in && wr_in) begin
      if (addr_in == CTRL_OFFSET) begin
        ctrl_word <= wr_data_in[3:0];
      end
      if (addr_in == CONFIG_OFFSET) begin
        config_bits <= wr_data_in[1:0];
      end
    end
  end

  // read data stands only in the cycle after the strobe;
  // unmapped offsets and idle cycles read as zero
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_out <= '0;
    end else if (ce_in) begin
      rd_data_out <= '0;
      if (rd_in) begin
        unique case (addr_in)
          CTRL_OFFSET: begin
            rd_data_out[3:0] <= ctrl_word;
          end
          CONFIG_OFFSET: begin
            rd_data_out[1:0] <= config_bits;
          end
          STATUS_OFFSET: begin
            rd_data_out[STAT_STATE_LSB +: 7] <= state;
            rd_data_out[STAT_MOTOR_BIT]      <= drive.motor_on;
            rd_data_out[STAT_RAMPN_BIT]      <= drive.ramp_normal;
            rd_data_out[STAT_RAMPQ_BIT]      <= drive.ramp_quick;
          end
          default: begin
            rd_data_out <= '0;
          end
        endcase
      end
    end
  end

  // checks; a frozen cycle holds everything, so each antecedent
  // requires the enable at the edge that makes the move
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);

  // quiet command set: no stop pending
  sequence s_no_stop;
    ce_in && !hard_stop(cmd);
  endsequence

  // power-up with on held and auto start on, then first step up
  sequence s_auto_power_on;
    ce_in && state == state_power_up && cmd.on_cmd &&
    auto_start && !hard_stop(cmd);
  endsequence

  // on still held and no stop in the ready state that follows
  sequence s_auto_ready_on;
    state == state_ready_to_switch_on ##0 s_no_stop ##0 cmd.on_cmd;
  endsequence

  a_power_up_ready: assert property (
    ce_in && state == state_power_up && !cmd.on_cmd && !hard_stop(cmd)
    |=> state == state_ready_to_switch_on && !motor_on_out)
    else $error("power-up did not reach ready to switch on");

  a_power_up_inhibit: assert property (
    ce_in && state == state_power_up && cmd.on_cmd && !auto_start
    |=> state == state_switch_on_inhibited)
    else $error("on at power-up did not inhibit");

  a_auto_start_ready: assert property (
    s_auto_power_on |=> state == state_ready_to_switch_on)
    else $error("auto start did not reach ready");

  a_auto_start_run: assert property (
    s_auto_power_on ##1 s_auto_ready_on |=> state == state_await_enable)
    else $error("auto start did not advance");

  a_inhibit_ignores_on: assert property (
    ce_in && state == state_switch_on_inhibited && cmd.on_cmd
    |=> state == state_switch_on_inhibited && !motor_on_out)
    else $error("inhibited state reacted to on");

  a_no_bypass: assert property (
    $rose(motor_on_out) |-> $past(state) == state_await_enable)
    else $error("motor switched on without the ready path");

  a_enable_gate: assert property (
    ce_in && state == state_await_enable && !cmd.op_enable
    |=> !motor_on_out && state != state_operation)
    else $error("operation entered without enable");

  // enable withdrawn while running drops drive and waits again
  a_enable_drop: assert property (
    ce_in && state == state_operation && cmd.on_cmd && !hard_stop(cmd) &&
    !cmd.op_enable |=> state == state_await_enable && !motor_on_out)
    else $error("lost enable did not drop drive");

  a_switch_on: assert property (
    ce_in && state == state_await_enable && cmd.on_cmd &&
    cmd.op_enable && !hard_stop(cmd)
    |=> state == state_operation && motor_on_out)
    else $error("switch-on did not energise");

  a_ramped_brake: assert property (
    ce_in && state == state_operation && !cmd.on_cmd && !hard_stop(cmd)
    |=> state == state_normal_stop && ramp_normal_out && motor_on_out)
    else $error("ramped stop not on normal ramp");

  a_ramped_done: assert property (
    ce_in && state == state_normal_stop && zero_speed_in &&
    !hard_stop(cmd)
    |=> state == state_ready_to_switch_on && !motor_on_out)
    else $error("ramped stop did not end ready");

  a_coast_off: assert property (
    ce_in && cmd.coast_stop_cmd && state != state_power_up
    |=> !motor_on_out && !ramp_normal_out && !ramp_quick_out)
    else $error("coast stop left drive on");

  a_quick_brake: assert property (
    ce_in && energised(state) && state != state_fast_stop &&
    cmd.quick_stop_cmd && !cmd.coast_stop_cmd
    |=> state == state_fast_stop && ramp_quick_out && !ramp_normal_out)
    else $error("quick stop not on quick ramp");

  a_stop_inhibits: assert property (
    ce_in && hard_stop(cmd) && !energised(state)
    |=> state == state_switch_on_inhibited)
    else $error("stop command did not inhibit");

  a_fast_done: assert property (
    ce_in && state == state_fast_stop && zero_speed_in
    |=> state == state_switch_on_inhibited && !motor_on_out)
    else $error("quick stop standstill left drive on");

  a_terminal_enable: assert property (
    !config_bits[CFG_BUS_BIT] |-> cmd.op_enable)
    else $error("terminal control lacks enable");

  a_stop_report: assert property (
    ramp_normal_out |-> !ramp_quick_out ##0
    state == state_normal_stop)
    else $error("braking report does not match state");

  a_stop_priority: assert property (
    ce_in && state == state_normal_stop && cmd.quick_stop_cmd &&
    !cmd.coast_stop_cmd |=> state == state_fast_stop)
    else $error("quick stop lost to ramped stop");

endmodule : drive_on_off_sequencer

/* verilog/drive_seq_pkg.sv */
package drive_seq_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;  // command word
  localparam logic [7:0] CONFIG_OFFSET = 8'h04;  // options
  localparam logic [7:0] STATUS_OFFSET = 8'h08;  // sequencer state

  // command word field positions
  localparam int unsigned CTRL_ON_BIT     = 0;
  localparam int unsigned CTRL_COAST_BIT  = 1;
  localparam int unsigned CTRL_QUICK_BIT  = 2;
  localparam int unsigned CTRL_ENABLE_BIT = 3;

  // option field positions
  localparam int unsigned CFG_AUTO_BIT = 0;  // automatic start
  localparam int unsigned CFG_BUS_BIT  = 1;  // 1: fieldbus word

  // status field positions
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_MOTOR_BIT = 8;
  localparam int unsigned STAT_RAMPN_BIT = 9;
  localparam int unsigned STAT_RAMPQ_BIT = 10;

  // values after reset
  localparam logic [3:0] CTRL_RESET   = 4'h0;
  localparam logic [1:0] CONFIG_RESET = 2'h0;

  // sequencer states, one-hot
  typedef enum logic [6:0] {
    state_power_up            = 7'h01,
    state_switch_on_inhibited = 7'h02,
    state_ready_to_switch_on  = 7'h04,
    state_await_enable        = 7'h08,
    state_operation           = 7'h10,
    state_normal_stop         = 7'h20,
    state_fast_stop           = 7'h40
  } seq_state_e;

  // resolved command set from the selected source
  typedef struct packed {
    logic on_cmd;          // switch-on request (low means ramped stop)
    logic coast_stop_cmd;  // remove drive at once
    logic quick_stop_cmd;  // brake on the quick-stop ramp
    logic op_enable;       // operating enable
  } cmd_s;

  // drive-side outputs
  typedef struct packed {
    logic motor_on;     // power stage energised
    logic ramp_normal;  // ramp generator uses normal ramp-down time
    logic ramp_quick;   // ramp generator uses quick-stop ramp-down time
  } drive_s;

endpackage : drive_seq_pkg

/* verification/ramp_gen_model.sv */
// far-side ramp generator: reports standstill a set time after braking
module ramp_gen_model
  import drive_seq_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  // braking requests from the sequencer
  input  wire logic       ramp_normal_in,
  input  wire logic       ramp_quick_in,
  // cycles of braking before standstill, 0 answers at once
  input  wire logic [3:0] delay_in,
  // standstill back to the sequencer
  output logic            zero_speed_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic       braking;  // either ramp is active
  logic [3:0] count;    // cycles spent braking so far

  assign braking = ramp_normal_in | ramp_quick_in;

  // count braking cycles; restart whenever braking stops
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count <= 4'h0;
    end else if (!braking) begin
      count <= 4'h0;
    end else if (count != delay_in) begin
      count <= count + 4'h1;
    end
  end

  // standstill only while braking, so a stale flag never leaks out
  assign zero_speed_out = braking && (count == delay_in);
endmodule : ramp_gen_model

/* verification/drive_on_off_sequencer_tb_top.sv */
module drive_on_off_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import drive_seq_pkg::*;

  // expected drive outputs {motor, normal ramp, quick ramp}
  localparam drive_s OFF = 3'h0;
  localparam drive_s RUN = 3'h4;
  localparam drive_s RN  = 3'h6;
  localparam drive_s RQ  = 3'h5;

  logic              mclk_in, resetn_in, ce_in;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wr_data_in, rd_data_out;
  logic              wr_in, rd_in;
  logic              di_on_in, di_coast_stop_in, di_quick_stop_in;
  logic              zero_speed_in;
  logic              motor_on_out, ramp_normal_out, ramp_quick_out;
  logic [6:0]        state_out;
  logic [3:0]        stall;       // partner braking time
  int                mismatches;
  int                total_checks;

  drive_on_off_sequencer u_dut (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
    .rd_in(rd_in), .rd_data_out(rd_data_out), .di_on_in(di_on_in),
    .di_coast_stop_in(di_coast_stop_in),
    .di_quick_stop_in(di_quick_stop_in), .zero_speed_in(zero_speed_in),
    .motor_on_out(motor_on_out), .ramp_normal_out(ramp_normal_out),
    .ramp_quick_out(ramp_quick_out), .state_out(state_out));

  ramp_gen_model u_ramp (
    .mclk_in(mclk_in), .resetn_in(resetn_in),
    .ramp_normal_in(ramp_normal_out), .ramp_quick_in(ramp_quick_out),
    .delay_in(stall), .zero_speed_out(zero_speed_in));

  // 100 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // state and drive outputs against expectation
  task automatic chk_st(input seq_state_e s, input drive_s d);
    drive_s got;
    got = {motor_on_out, ramp_normal_out, ramp_quick_out};
    total_checks++;
    if (state_out !== s || got !== d) begin
      mismatches++;
      $display("ERROR state exp %h/%b seen %h/%b", s, d, state_out, got);
    end
  endtask : chk_st

  // register read data against expectation
  task automatic chk_rd(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s exp %h seen %h", nm, e, g);
    end
  endtask : chk_rd

  // bounded wait for a state; running out ends the run
  task automatic wait_st(input seq_state_e s, input drive_s d, input int n);
    int i;
    i = 0;
    do begin
      @(posedge mclk_in);
      #1;
      i++;
    end while (state_out !== s && i < n);
    chk_st(s, d);
    if (state_out !== s) begin
      test_done();
    end
  endtask : wait_st

  // digital command levels, applied at a rising edge
  task automatic drv(input logic on, input logic c, input logic q);
    @(posedge mclk_in);
    di_on_in         <= on;
    di_coast_stop_in <= c;
    di_quick_stop_in <= q;
  endtask : drv

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    wr_in      <= 1'b1;
    addr_in    <= a;
    wr_data_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    @(posedge mclk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    chk_rd(nm, e, rd_data_out);
  endtask : rd

  // reset for 9 cycles with the switch-on level given, then power up
  task automatic do_reset(input logic on, input seq_state_e s);
    @(posedge mclk_in);
    resetn_in <= 1'b0;
    di_on_in  <= on;
    repeat (8) @(posedge mclk_in);
    #1;
    chk_st(state_power_up, OFF);
    chk_rd("rd_data in reset", 32'h0, rd_data_out);
    @(posedge mclk_in);
    resetn_in <= 1'b1;
    wait_st(s, OFF, 1);
  endtask : do_reset

  task automatic s_power_up();
    do_reset(1'b0, state_ready_to_switch_on);
    rd(CTRL_OFFSET, 32'h0, "ctrl reset");
    rd(CONFIG_OFFSET, 32'h0, "config reset");
    rd(8'h0C, 32'h0, "unmapped");
  endtask : s_power_up

  task automatic s_ramped();
    stall <= 4'h3;
    drv(1'b1, 1'b0, 1'b0);
    wait_st(state_await_enable, OFF, 1);
    wait_st(state_operation, RUN, 1);
    // clock enable low must freeze the stop request
    @(posedge mclk_in);
    ce_in    <= 1'b0;
    di_on_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1;
    chk_st(state_operation, RUN);
    @(posedge mclk_in);
    ce_in <= 1'b1;
    wait_st(state_normal_stop, RN, 1);
    wait_st(state_ready_to_switch_on, OFF, 8);
  endtask : s_ramped

  task automatic s_quick();
    drv(1'b1, 1'b0, 1'b0);
    wait_st(state_operation, RUN, 4);
    drv(1'b1, 1'b0, 1'b1);
    wait_st(state_fast_stop, RQ, 1);
    wait_st(state_switch_on_inhibited, OFF, 8);
    drv(1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge mclk_in);
    #1;
    chk_st(state_switch_on_inhibited, OFF);
    drv(1'b0, 1'b0, 1'b0);
    wait_st(state_ready_to_switch_on, OFF, 4);
  endtask : s_quick

  // stops overtake each other while the ramp is still running
  task automatic s_coast();
    stall <= 4'hF;
    drv(1'b1, 1'b0, 1'b0);
    wait_st(state_operation, RUN, 4);
    drv(1'b0, 1'b0, 1'b0);
    wait_st(state_normal_stop, RN, 1);
    drv(1'b0, 1'b0, 1'b1);
    wait_st(state_fast_stop, RQ, 1);
    drv(1'b0, 1'b1, 1'b1);
    wait_st(state_switch_on_inhibited, OFF, 1);
    drv(1'b0, 1'b0, 1'b0);
    wait_st(state_ready_to_switch_on, OFF, 4);
  endtask : s_coast

  task automatic s_powerup_on();
    do_reset(1'b1, state_switch_on_inhibited);
    drv(1'b0, 1'b0, 1'b0);
    wait_st(state_ready_to_switch_on, OFF, 4);
  endtask : s_powerup_on

  // auto start written on the first edge after reset lets a held on run
  task automatic s_auto_start();
    @(posedge mclk_in);
    resetn_in <= 1'b0;
    di_on_in  <= 1'b1;
    repeat (8) @(posedge mclk_in);
    resetn_in  <= 1'b1;
    wr_in      <= 1'b1;
    addr_in    <= CONFIG_OFFSET;
    wr_data_in <= 32'h1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    #1;
    chk_st(state_ready_to_switch_on, OFF);
    wait_st(state_operation, RUN, 4);
    rd(CONFIG_OFFSET, 32'h1, "config auto");
    drv(1'b0, 1'b0, 1'b0);
    wait_st(state_normal_stop, RN, 4);
    wait_st(state_ready_to_switch_on, OFF, 20);
  endtask : s_auto_start

  task automatic s_fieldbus();
    logic [31:0] run_stat;
    run_stat = 32'h10 | (32'h1 << STAT_MOTOR_BIT);
    wr(CONFIG_OFFSET, 32'h2);
    wr(CTRL_OFFSET, 32'h1);
    wait_st(state_await_enable, OFF, 4);
    repeat (4) @(posedge mclk_in);
    #1;
    chk_st(state_await_enable, OFF);
    rd(STATUS_OFFSET, 32'h8, "status await");
    wr(CTRL_OFFSET, 32'h9);
    wait_st(state_operation, RUN, 4);
    rd(STATUS_OFFSET, run_stat, "status run");
    @(posedge mclk_in);
    #1;
    chk_rd("rd_data idle", 32'h0, rd_data_out);
    wr(STATUS_OFFSET, 32'h0);
    rd(STATUS_OFFSET, run_stat, "status kept");
    rd(CTRL_OFFSET, 32'h9, "ctrl");
    rd(CONFIG_OFFSET, 32'h2, "config");
    wr(CTRL_OFFSET, 32'h1);
    wait_st(state_await_enable, OFF, 4);
    wr(CTRL_OFFSET, 32'h9);
    wait_st(state_operation, RUN, 4);
    wr(CTRL_OFFSET, 32'h8);
    wait_st(state_normal_stop, RN, 4);
    wait_st(state_ready_to_switch_on, OFF, 20);
  endtask : s_fieldbus

  initial begin
    mismatches       = 0;
    total_checks     = 0;
    resetn_in        = 1'b0;
    ce_in            = 1'b1;
    addr_in          = 8'h00;
    wr_data_in       = 32'h0;
    wr_in            = 1'b0;
    rd_in            = 1'b0;
    di_on_in         = 1'b0;
    di_coast_stop_in = 1'b0;
    di_quick_stop_in = 1'b0;
    stall            = 4'h3;
    s_power_up();
    s_ramped();
    s_quick();
    s_coast();
    s_powerup_on();
    s_auto_start();
    s_fieldbus();
    test_done();
  end

  // last guard against a hang
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
endmodule : drive_on_off_sequencer_tb_top
